// ### hw/wdog_pkg.sv
// Purpose: constants and types for the watchdog timer unit
// Assumes: 32-bit APB, one word per register, byte addresses below
// Notes:
// Summary of operation
// - 16-bit up counter ticks on cpu clock divided by 2 or 128.
// - two cascaded 8-bit stages; service presets upper, clears lower.
// - after any reset: enabled, count zero, divide-by-2 selected.
// - prescaler_select set switches input from divide-by-2 to divide-by-128.
// - disable only accepted before first end-of-init or service instruction.
// - counting continues during idle unless disabled.
// - overflow without service requests system reset and sets reset flag.
// - service clears low byte, loads high byte from reload value.
// - every service clears the watchdog reset flag.
// - malformed service instruction does not service; raises protection fault.
// - period equals 2^(1+6*sel) times (65536 - reload*256) cpu cycles.
// - counter stops in power down mode.
// - in idle, overflow before wake interrupt still requests reset.
// - count register is read only; writes leave count unchanged.
// - end-of-init clears all reset source flags in control register.
package wdog_pkg;
  localparam logic [11:0] ADDR_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_COUNT = 12'h004;
  localparam logic [11:0] ADDR_COMMAND = 12'h008;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h00C;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h010;
  localparam logic [11:0] ADDR_STATE = 12'h014;
  // control field positions
  localparam int CTL_SEL_BIT = 0;
  localparam int CTL_WDR_BIT = 1;
  localparam int CTL_SWR_BIT = 2;
  localparam int CTL_SHWR_BIT = 3;
  localparam int CTL_LHWR_BIT = 4;
  localparam int CTL_RELOAD_LSB = 8;
  // command encodings; protected form needs key in upper half
  localparam logic [15:0] CMD_KEY = 16'hA55A;
  localparam logic [15:0] CMD_SERVICE = 16'h0001;
  localparam logic [15:0] CMD_DISABLE = 16'h0002;
  localparam logic [15:0] CMD_END_OF_INIT_INSTRUCTION = 16'h0003;
  // irq status bits
  localparam int IRQ_OVF_BIT = 0;
  localparam int IRQ_FAULT_BIT = 1;
  localparam logic [7:0] PRESC_SLOW = 8'h7F;
  localparam logic [7:0] PRESC_FAST = 8'h01;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  typedef struct packed {
    logic [7:0] reload;
    logic lhwr;
    logic shwr;
    logic swr;
    logic wdr;
    logic sel;
  } control_s;
  typedef enum logic [0:0] {ST_OPEN, ST_LOCKED} init_e;
endpackage

// ### hw/watchdog_timer_unit.sv
// Purpose: watchdog timer unit with apb register access
// Assumes: reset source flags come from the system reset logic as synced levels
// Notes: idle leaves counting untouched; power down freezes the counter
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/100ps
module watchdog_timer_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_down,
  input wire logic src_sw_reset,
  input wire logic src_short_hw_reset,
  input wire logic src_long_hw_reset,
  input wire logic src_wdog_reset,
  output logic sys_reset_req,
  output logic protection_fault,
  output logic irq
);
  import wdog_pkg::*;

  logic [1:0] pd_sync_q, pd_sync_d;
  logic [15:0] count_q, count_d;
  logic [7:0] presc_q, presc_d;
  control_s ctl_q, ctl_d;
  logic first_q, first_d;
  init_e init_q, init_d;
  logic enabled_q, enabled_d;
  logic rst_req_q, rst_req_d;
  logic fault_q, fault_d;
  logic [1:0] ists_q, ists_d;
  logic [1:0] imask_q, imask_d;
  logic irq_q, irq_d;
  logic [31:0] rdata_q, rdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;

  logic wr_acc;
  logic rd_setup;
  logic cmd_wr;
  logic cmd_known;
  logic do_srv;
  logic do_dis;
  logic do_end_of_init_instruction;
  logic counting;
  logic tick;
  logic ovf;
  logic [7:0] presc_max;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a == r);
  endfunction

  // protected form: key in the upper half, code in the lower
  function automatic logic cmd_is(input logic [31:0] w, input logic [15:0] c);
    cmd_is = (w[31:16] == CMD_KEY) && (w[15:0] == c);
  endfunction

  assign wr_acc = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign cmd_wr = wr_acc & hit(paddr, ADDR_COMMAND);
  assign cmd_known = cmd_is(pwdata, CMD_SERVICE) | cmd_is(pwdata, CMD_END_OF_INIT_INSTRUCTION)
                     | cmd_is(pwdata, CMD_DISABLE);
  assign do_srv = cmd_wr & cmd_is(pwdata, CMD_SERVICE);
  assign do_end_of_init_instruction = cmd_wr & cmd_is(pwdata, CMD_END_OF_INIT_INSTRUCTION);
  assign do_dis = cmd_wr & cmd_is(pwdata, CMD_DISABLE) & (init_q == ST_OPEN);
  assign presc_max = ctl_q.sel ? PRESC_SLOW : PRESC_FAST;
  assign counting = enabled_q & ~pd_sync_q[1];
  assign tick = counting & (presc_q >= presc_max);
  assign ovf = tick & (count_q == 16'hFFFF);

  // power down pin passes two flops before use
  always_comb begin
    pd_sync_d = {pd_sync_q[0], power_down};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_sync_q <= 2'b00;
    end else if (clk_en) begin
      pd_sync_q <= pd_sync_d;
    end
  end

  always_comb begin
    count_d = count_q;
    presc_d = presc_q;
    if (counting) begin
      if (tick) begin
        presc_d = 8'h00;
      end else begin
        presc_d = presc_q + 8'h01;
      end
    end
    if (tick) begin
      count_d[7:0] = count_q[7:0] + 8'h01;
      if (count_q[7:0] == 8'hFF) begin
        count_d[15:8] = count_q[15:8] + 8'h01;
      end
    end
    if (do_srv) begin
      count_d = {ctl_q.reload, 8'h00};
      presc_d = 8'h00;
    end
  end

  // enabled, zero, divide by 2 after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= COUNT_RESET;
      presc_q <= 8'h00;
    end else if (clk_en) begin
      count_q <= count_d;
      presc_q <= presc_d;
    end
  end

  always_comb begin
    ctl_d = ctl_q;
    first_d = 1'b0;
    // reset source flags caught once after release
    if (first_q) begin
      ctl_d.swr = src_sw_reset;
      ctl_d.shwr = src_short_hw_reset;
      ctl_d.lhwr = src_long_hw_reset;
      ctl_d.wdr = src_wdog_reset;
    end
    if (ovf) begin
      ctl_d.wdr = 1'b1;
    end
    if (wr_acc & hit(paddr, ADDR_CONTROL)) begin
      if (pstrb[0]) begin
        ctl_d.sel = pwdata[CTL_SEL_BIT];
      end
      if (pstrb[1]) begin
        ctl_d.reload = pwdata[CTL_RELOAD_LSB +: 8];
      end
    end
    if (do_srv) begin
      ctl_d.wdr = 1'b0;
    end
    if (do_end_of_init_instruction) begin
      ctl_d.wdr = 1'b0;
      ctl_d.swr = 1'b0;
      ctl_d.shwr = 1'b0;
      ctl_d.lhwr = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= '0;
      first_q <= 1'b1;
    end else if (clk_en) begin
      ctl_q <= ctl_d;
      first_q <= first_d;
    end
  end

  always_comb begin
    init_d = init_q;
    enabled_d = enabled_q;
    // either instruction closes the disable window for good
    if (do_srv | do_end_of_init_instruction) begin
      init_d = ST_LOCKED;
    end
    if (do_dis) begin
      enabled_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_q <= ST_OPEN;
      enabled_q <= 1'b1;
    end else if (clk_en) begin
      init_q <= init_d;
      enabled_q <= enabled_d;
    end
  end

  always_comb begin
    rst_req_d = ovf;
    // bad format traps; a late disable is dropped quietly
    fault_d = cmd_wr & ~cmd_known;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_req_q <= 1'b0;
      fault_q <= 1'b0;
    end else if (clk_en) begin
      rst_req_q <= rst_req_d;
      fault_q <= fault_d;
    end
  end

  always_comb begin
    ists_d = ists_q;
    imask_d = imask_q;
    if (wr_acc & hit(paddr, ADDR_IRQ_STATUS) & pstrb[0]) begin
      ists_d = ists_q & ~pwdata[1:0];
    end
    if (wr_acc & hit(paddr, ADDR_IRQ_MASK) & pstrb[0]) begin
      imask_d = pwdata[1:0];
    end
    // set after clear, so a new event wins
    if (ovf) begin
      ists_d[IRQ_OVF_BIT] = 1'b1;
    end
    if (fault_d) begin
      ists_d[IRQ_FAULT_BIT] = 1'b1;
    end
    irq_d = |(ists_d & imask_d);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ists_q <= 2'b00;
      imask_q <= 2'b00;
      irq_q <= 1'b0;
    end else if (clk_en) begin
      ists_q <= ists_d;
      imask_q <= imask_d;
      irq_q <= irq_d;
    end
  end

  // read data is caught in the setup cycle and held until the next read
  always_comb begin
    rdata_d = rdata_q;
    if (rd_setup) begin
      case (paddr)
        ADDR_CONTROL: begin
          rdata_d = {16'h0000, ctl_q.reload, 3'b000, ctl_q.lhwr,
                     ctl_q.shwr, ctl_q.swr, ctl_q.wdr, ctl_q.sel};
        end
        ADDR_COUNT: begin
          rdata_d = {16'h0000, count_q};
        end
        ADDR_IRQ_STATUS: begin
          rdata_d = {30'h0, ists_q};
        end
        ADDR_IRQ_MASK: begin
          rdata_d = {30'h0, imask_q};
        end
        ADDR_STATE: begin
          rdata_d = {30'h0, init_q == ST_LOCKED, enabled_q};
        end
        default: begin
          rdata_d = ZERO_WORD;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= ZERO_WORD;
    end else if (clk_en) begin
      rdata_q <= rdata_d;
    end
  end

  // no wait states and no error; still taken from a flop like every output
  always_comb begin
    pready_d = 1'b1;
    pslverr_d = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b1;
      pslverr_q <= 1'b0;
    end else if (clk_en) begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = rdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign sys_reset_req = rst_req_q;
  assign protection_fault = fault_q;
  assign irq = irq_q;
endmodule

// ### dv/wdog_monitor.sv
// Purpose: port checks for the watchdog timer unit
// Assumes: clk_en held high
// Notes: irq moves at the same edge as its cause
`timescale 1ns/100ps
module wdog_monitor
  import wdog_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic power_down,
  input wire logic sys_reset_req,
  input wire logic protection_fault,
  input wire logic irq
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic w = psel && penable && pwrite;
  wire logic svc = w && paddr == ADDR_COMMAND && pwdata == {CMD_KEY, CMD_SERVICE};
  req_pulse_a: assert property (sys_reset_req |=> !sys_reset_req [*8])
    else $error("reset request too long");
  svc_quiet_a: assert property (svc |=> ##1 !sys_reset_req [*8])
    else $error("reset request after service");
  pd_freeze_a: assert property (power_down [*5] |-> !sys_reset_req)
    else $error("reset request in power down");
  fault_pulse_a: assert property (protection_fault |=> !protection_fault)
    else $error("fault too long");
  fault_cause_a: assert property (
    protection_fault |-> $past(w && paddr == ADDR_COMMAND)) else $error("fault without command");
  irq_rise_a: assert property ($rose(irq) |-> sys_reset_req ||
    protection_fault || $past(w && paddr == ADDR_IRQ_MASK)) else $error("irq rise");
  irq_fall_a: assert property (
    $fell(irq) |-> $past(w && paddr >= ADDR_IRQ_STATUS)) else $error("irq fall");
  bus_ok_a: assert property (pready && !pslverr)
    else $error("bus answer");
endmodule
bind watchdog_timer_unit wdog_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .power_down, .sys_reset_req, .protection_fault, .irq);

// ### dv/wdog_rst_src.sv
// Purpose: reset source logic beside the watchdog
// Assumes: the run starts from a power-up long hardware reset
// Notes: never resets the chip itself; the bench does that
`timescale 1ns/100ps
module wdog_rst_src (
  input wire logic pclk,
  input wire logic sys_reset_req,
  output logic src_sw_reset = 1'h1,
  output logic src_short_hw_reset = 1'h1,
  output logic src_long_hw_reset = 1'h1,
  output logic src_wdog_reset = 1'h0
);
  // a watchdog reset also marks software reset, so sw stays high
  always @(posedge pclk) begin
    if (sys_reset_req) begin
      src_wdog_reset <= 1'h1;
      src_short_hw_reset <= 1'h0;
      src_long_hw_reset <= 1'h0;
    end
  end
endmodule

// ### dv/watchdog_timer_unit_tb_top.sv
// Purpose: bench for the watchdog timer unit
// Assumes: apb access phase ends when pready is seen
// Notes: reload FF keeps overflow waits short
`timescale 1ns/100ps
module watchdog_timer_unit_tb_top;
  import wdog_pkg::*;
  logic pclk = 1'h0, presetn = 1'h0, power_down = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, pready, pslverr, sys_reset_req, protection_fault, irq, sw, sh, lh, wd;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q, r;
  int n_errors = 0, n_compared = 0, cyc = 0, n;
  watchdog_timer_unit dut (.pclk, .presetn, .clk_en(1'h1), .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr, .power_down, .src_sw_reset(sw),
    .src_short_hw_reset(sh), .src_long_hw_reset(lh), .src_wdog_reset(wd), .sys_reset_req,
    .protection_fault, .irq);
  wdog_rst_src far (.pclk, .sys_reset_req, .src_sw_reset(sw), .src_short_hw_reset(sh),
    .src_long_hw_reset(lh), .src_wdog_reset(wd));
  initial begin
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic close_out();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic ck(input string s, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", s, exp, got);
    end
  endtask
  task automatic ap(input logic [11:0] a, input logic [31:0] d, input logic wr);
    psel <= 1'h1;
    paddr <= a;
    pwdata <= d;
    pwrite <= wr;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1)
      @(posedge pclk);
    q = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic cmd(input logic [15:0] c);
    ap(ADDR_COMMAND, {CMD_KEY, c}, 1'h1);
  endtask
  task automatic rst();
    presetn <= 1'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
  endtask
  // overflow wait; the timeout bounds it
  task automatic ovf();
    n = 0;
    while (sys_reset_req !== 1'h1) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic t_boot();
    ap(ADDR_CONTROL, 32'h0, 1'h0);
    ck("ctl", q, 32'h1C);
    cmd(CMD_DISABLE);
    ap(ADDR_STATE, 32'h0, 1'h0);
    ck("off", q[0], 32'h0);
  endtask
  task automatic t_fault();
    ap(ADDR_COMMAND, 32'h1234_0001, 1'h1);
    ap(ADDR_IRQ_STATUS, 32'h0, 1'h0);
    ck("fault", q, 32'h2);
    ck("masked", irq, 32'h0);
    ap(ADDR_IRQ_MASK, 32'h3, 1'h1);
    ck("irq", irq, 32'h1);
    ap(ADDR_STATE, 32'h0, 1'h0);
    ck("open", q, 32'h1);
    ap(ADDR_IRQ_STATUS, 32'h2, 1'h1);
    @(posedge pclk);
    ck("clr", irq, 32'h0);
  endtask
  task automatic t_lock();
    cmd(CMD_END_OF_INIT_INSTRUCTION);
    ap(ADDR_CONTROL, 32'h0, 1'h0);
    ck("flags", q, 32'h0);
    cmd(CMD_DISABLE);
    ap(ADDR_STATE, 32'h0, 1'h0);
    ck("lock", q, 32'h3);
  endtask
  task automatic t_ovf();
    ap(ADDR_CONTROL, 32'hFF00, 1'h1);
    cmd(CMD_SERVICE);
    ovf();
    ck("period", 32'(n > 505 && n < 515), 32'h1);
    repeat (2) @(posedge pclk);
    ck("irq", irq, 32'h1);
    ap(ADDR_CONTROL, 32'h0, 1'h0);
    ck("wdr", q, 32'hFF02);
    cmd(CMD_SERVICE);
    ap(ADDR_COUNT, 32'h0, 1'h1);
    ap(ADDR_COUNT, 32'h0, 1'h0);
    ck("ro", q[15:8], 32'hFF);
    ap(ADDR_CONTROL, 32'h0, 1'h0);
    ck("svc", q, 32'hFF00);
    ap(ADDR_IRQ_STATUS, 32'h1, 1'h1);
  endtask
  task automatic t_slow();
    power_down <= 1'h1;
    repeat (4) @(posedge pclk);
    ap(ADDR_COUNT, 32'h0, 1'h0);
    r = q;
    repeat (40) @(posedge pclk);
    ap(ADDR_COUNT, 32'h0, 1'h0);
    ck("frozen", q, r);
    power_down <= 1'h0;
    ap(ADDR_CONTROL, 32'hFF01, 1'h1);
    cmd(CMD_SERVICE);
    ovf();
    ck("slow", 32'(n > 32640 && n < 32900), 32'h1);
    rst();
    ap(ADDR_CONTROL, 32'h0, 1'h0);
    ck("wd ctl", q, 32'h6);
  endtask
  initial begin
    rst();
    t_boot();
    rst();
    t_fault();
    t_lock();
    t_ovf();
    t_slow();
    close_out();
  end
endmodule
